// ==== dv/bbs_host_assertions.sv ====
// Purpose: port checks of the sram host
// Assumes: one clock, rst async high
// Notes: select and write strobes move together in writes
module bbs_host_assertions (
    // clock, reset, user side
    input wire logic clock,
    input wire logic rst,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic power_fail,
    input wire logic protected_o,
    // memory pins
    input wire bbs_pkg::bbs_pins_t pins,
    input wire logic [7:0] byte_lines_out,
    input wire logic byte_lines_oe_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_addr_setup: assert property ($fell(pins.cs_n) |-> $stable(pins.addr))
        else $error("address moved at select");
    a_addr_write: assert property (!pins.we_n && !$past(pins.we_n) |-> $stable(pins.addr))
        else $error("address moved in write");
    a_addr_hold: assert property ($rose(pins.cs_n) |-> $stable(pins.addr))
        else $error("address moved at end");
    a_oe_quiet: assert property (!pins.we_n |-> pins.oe_n)
        else $error("output enable low in write");
    a_data_setup: assert property (!pins.we_n |-> !byte_lines_oe_n && $stable(byte_lines_out))
        else $error("write data not steady");
    a_data_hold: assert property ($rose(pins.we_n) |-> !byte_lines_oe_n && $stable(byte_lines_out))
        else $error("write data not held");
    a_wr_width: assert property ($fell(pins.we_n) |-> !pins.we_n [*2])
        else $error("write strobe too short");
    a_cs_width: assert property ($fell(pins.cs_n) |-> !pins.cs_n [*2])
        else $error("select strobe too short");
    a_no_clash: assert property (!pins.oe_n |-> byte_lines_oe_n)
        else $error("host drives data during read");
    a_no_take: assert property (power_fail || protected_o |-> !req_ready)
        else $error("request taken while protected");
    a_read_answer: assert property ($fell(pins.oe_n) |-> ##[1:6] rsp_valid)
        else $error("read not answered");
    c_write: cover property ($fell(pins.we_n));
    c_read: cover property ($fell(pins.oe_n));
    c_prot: cover property ($fell(protected_o));
endmodule : bbs_host_assertions
bind bbs_host bbs_host_assertions u_bbs_host_assertions (.clock(clock), .rst(rst),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .power_fail(power_fail),
    .protected_o(protected_o), .pins(pins), .byte_lines_out(byte_lines_out),
    .byte_lines_oe_n(byte_lines_oe_n));

// ==== dv/bbs_host_tb.sv ====
// Purpose: self-checking bench of the sram host
// Assumes: recovery shortened to 20 cycles, protect delay to 10
// Notes: inputs move 2 ns after the rising edge
module bbs_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, power_fail = 1'b0;
    bbs_pkg::bbs_req_t req = '0;
    bbs_pkg::bbs_pins_t pins;
    logic req_ready, rsp_valid, protected_o, dq_oe_n;
    logic [7:0] rsp_data, dq_in, dq_out, dq_dev, q;
    int failures = 0, comparisons = 0, cycles = 0;
    always #25 clock = ~clock;
    assign dq_in = dq_oe_n ? dq_dev : dq_out;
    bbs_host #(.RECOVERY_CYC(20)) u_bbs_host (.clock(clock), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .power_fail(power_fail), .protected_o(protected_o), .pins(pins),
        .byte_lines_in(dq_in), .byte_lines_out(dq_out), .byte_lines_oe_n(dq_oe_n));
    bbs_sram_model #(.PROT_CYC(10), .REC_CYC(20)) u_bbs_sram_model (.clock(clock),
        .power_fail(power_fail),
        .pins(pins), .dq_in(dq_in), .dq_out(dq_dev));
    task automatic end_of_test;
        if (failures == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic check_b(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check_b
    task automatic check_f(input logic g, input logic e);
        check_b({7'h00, g}, {7'h00, e});
    endtask : check_f
    // held until taken, answer caught in its one pulse cycle
    task automatic access(input logic w, input logic [14:0] a, input logic [7:0] d);
        req_valid = 1'b1;
        req = '{w, a, d};
        while (req_ready !== 1'b1) @(posedge clock) #2;
        @(posedge clock) #2;
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(posedge clock) #2;
        q = rsp_data;
    endtask : access
    task automatic t_rw;
        logic [14:0] a [3] = '{15'h0000, 15'h7FFF, 15'h1234};
        for (int i = 0; i < 3; i++) begin
            access(1'b1, a[i], 8'hA5 ^ i[7:0]);
            check_b(q, 8'hA5 ^ i[7:0]);
        end
        for (int i = 0; i < 3; i++) begin
            access(1'b0, a[i], 8'h00);
            check_b(q, 8'hA5 ^ i[7:0]);
        end
    endtask : t_rw
    task automatic t_fail;
        power_fail = 1'b1;
        repeat (2) @(posedge clock) #2;
        check_f(req_ready, 1'b0);
        check_f(protected_o, 1'b1);
        repeat (15) @(posedge clock) #2;
        power_fail = 1'b0;
        repeat (10) @(posedge clock) #2;
        check_f(protected_o, 1'b1);
        check_f(req_ready, 1'b0);
        repeat (15) @(posedge clock) #2;
        check_f(req_ready, 1'b1);
        access(1'b0, 15'h1234, 8'h00);
        check_b(q, 8'hA7);
    endtask : t_fail
    task automatic t_midfail;
        // start from an idle port so the fail edge lands inside the strobe
        while (req_ready !== 1'b1) @(posedge clock) #2;
        fork
            access(1'b1, 15'h0042, 8'h99);
            begin
                repeat (2) @(posedge clock) #2;
                power_fail = 1'b1;
            end
        join
        check_b(q, 8'h99);
        repeat (12) @(posedge clock) #2;
        power_fail = 1'b0;
        repeat (25) @(posedge clock) #2;
        access(1'b0, 15'h0042, 8'h00);
        check_b(q, 8'h99);
    endtask : t_midfail
    initial begin
        repeat (6) @(posedge clock);
        #2 rst = 1'b0;
        @(posedge clock) #2;
        t_rw;
        t_fail;
        t_midfail;
        end_of_test;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            end_of_test;
        end
    end
endmodule : bbs_host_tb

// ==== dv/bbs_sram_model.sv ====
// Purpose: behavioural 32K x 8 battery-backed ram behind the host port
// Assumes: tb clock times the protection and recovery delays and the capture of the last driven byte
// Notes: undriven byte lines show the inverse of the last value
module bbs_sram_model #(
    parameter int PROT_CYC = 800,
    parameter int REC_CYC = 20
) (
    // clock and supply
    input wire logic clock,
    input wire logic power_fail,
    // pins
    input wire bbs_pkg::bbs_pins_t pins,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out
);
    logic [7:0] mem_q [0:32767];
    logic [7:0] last_q = 8'h00;
    logic wr_on = 1'b0;
    logic prot;
    logic drv;
    int fail_cnt = 0;
    int rec_cnt = 0;
    assign prot = fail_cnt >= PROT_CYC || rec_cnt != 0;
    always @(posedge clock) fail_cnt <= power_fail ? fail_cnt + 1 : 0;
    // protection outlives the fail input by the recovery interval
    always @(posedge clock) begin
        rec_cnt <= (fail_cnt >= PROT_CYC) ? REC_CYC : ((rec_cnt > 0) ? rec_cnt - 1 : 0);
    end
    // float unless selected, reading and unprotected
    assign drv = !pins.cs_n && !pins.oe_n && pins.we_n && !prot;
    // released lines keep the inverse of the last driven byte, not a toggling one
    always @(posedge clock) begin
        if (drv) last_q <= dq_out;
    end
    assign dq_out = drv ? mem_q[pins.addr] : ~last_q;
    always @(pins or prot) begin
        if (wr_on && (pins.cs_n || pins.we_n)) mem_q[pins.addr] = dq_in;
        wr_on = !pins.cs_n && !pins.we_n && !prot;
    end
endmodule : bbs_sram_model

// ==== src/bbs_host.sv ====
// Purpose: host controller driving a 32K x 8 battery-backed static ram
// Assumes: one 20 MHz clock; pins synchronous; power fail seen as one input
// Notes: chip-select controlled cycles; in writes, write enable and select move together
module bbs_host #(
    parameter bit GRADE_100 = 1'b0,
    parameter int RECOVERY_CYC = bbs_pkg::RECOVERY_CYC_DEFAULT
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // user request
    input wire logic req_valid,
    output logic req_ready,
    input wire bbs_pkg::bbs_req_t req,
    // user answer
    output logic rsp_valid,
    output logic [bbs_pkg::DATA_W-1:0] rsp_data,
    // power state
    input wire logic power_fail,
    output logic protected_o,
    // memory pins
    output bbs_pkg::bbs_pins_t pins,
    input wire logic [bbs_pkg::DATA_W-1:0] byte_lines_in,
    output logic [bbs_pkg::DATA_W-1:0] byte_lines_out,
    output logic byte_lines_oe_n
);
    localparam int STRB_CYC = GRADE_100 ? bbs_pkg::WR_CYC_100 : bbs_pkg::WR_CYC_85;
    localparam int READ_CYC = GRADE_100 ? bbs_pkg::RD_CYC_100 : bbs_pkg::RD_CYC_85;

    bbs_pkg::bbs_state_t state_q, state_d;
    bbs_pkg::bbs_req_t cur_q;
    logic guard_q;
    logic pf_seen_q;
    logic ph_load;
    logic [7:0] ph_value;
    logic ph_done;
    logic rec_done;
    logic rec_load;

    // ****************************************
    // phase timer and recovery guard
    // ****************************************
    bbs_timer #(.W(8)) u_phase (
        .clock(clock),
        .rst(rst),
        .load(ph_load),
        .value(ph_value),
        .done(ph_done)
    );

    // reload each cycle the fail input is high, so guard runs after it clears
    assign rec_load = power_fail | pf_seen_q; // R23
    bbs_timer #(.W(32)) u_recover (
        .clock(clock),
        .rst(rst),
        .load(power_fail),
        .value(32'(RECOVERY_CYC)),
        .done(rec_done)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pf_seen_q <= 1'b0;
        end else begin
            pf_seen_q <= power_fail;
        end
    end

    // no access starts from fail until recovery ends; one already in its strobe still finishes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            guard_q <= 1'b0;
        end else begin
            guard_q <= rec_load | ~rec_done; // R18 R20 R23
        end
    end
    assign protected_o = guard_q;

    // ****************************************
    // access sequencer
    // ****************************************
    always_comb begin
        state_d = state_q;
        ph_load = 1'b0;
        ph_value = 8'h00;
        unique case (state_q)
            bbs_pkg::BBS_IDLE: begin
                if (req_valid && !guard_q && !power_fail) begin
                    state_d = bbs_pkg::BBS_SETUP;
                end
            end
            bbs_pkg::BBS_SETUP: begin
                // address settled one cycle before strobes fall
                state_d = bbs_pkg::BBS_STROBE; // R13
                ph_load = 1'b1;
                ph_value = 8'(cur_q.write ? STRB_CYC : READ_CYC); // R11 R12 R6 R14
            end
            bbs_pkg::BBS_STROBE: begin
                // started access completes even under power fail
                if (ph_done) begin
                    state_d = bbs_pkg::BBS_HOLD; // R21
                    ph_load = 1'b1;
                    ph_value = 8'(bbs_pkg::HOLD_CYC);
                end
            end
            bbs_pkg::BBS_HOLD: begin
                if (ph_done) begin
                    state_d = bbs_pkg::BBS_IDLE; // R5
                end
            end
            default: state_d = bbs_pkg::BBS_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= bbs_pkg::BBS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign req_ready = (state_q == bbs_pkg::BBS_IDLE) && !guard_q && !power_fail;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cur_q <= '0;
        end else if (req_valid && req_ready) begin
            cur_q <= req;
        end
    end

    // ****************************************
    // pins
    // ****************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pins <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
            byte_lines_out <= '0;
            byte_lines_oe_n <= 1'b1;
        end else begin
            // address stays put from setup through hold
            if (req_valid && req_ready) begin
                pins.addr <= req.addr; // R4 R13
                byte_lines_out <= req.wdata;
            end
            // select and write fall together so the device never drives
            pins.cs_n <= !(state_d == bbs_pkg::BBS_STROBE); // R2 R3 R9 R12
            pins.we_n <= !(state_d == bbs_pkg::BBS_STROBE && cur_q.write); // R11 R3
            pins.oe_n <= !(state_d == bbs_pkg::BBS_STROBE && !cur_q.write); // R7 R1
            // drive data through strobe and hold covers the 15 ns hold
            byte_lines_oe_n <= !(cur_q.write &&
                (state_d == bbs_pkg::BBS_STROBE || state_d == bbs_pkg::BBS_HOLD)); // R6 R10
        end
    end

    // ****************************************
    // read capture
    // ****************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_data <= '0;
        end else begin
            rsp_valid <= 1'b0;
            // sample at the last strobe cycle, access time already met
            if (state_q == bbs_pkg::BBS_STROBE && ph_done) begin
                rsp_valid <= 1'b1; // R14 R15
                rsp_data <= cur_q.write ? cur_q.wdata : byte_lines_in;
            end
        end
    end
endmodule : bbs_host

// ==== src/bbs_pkg.sv ====
// Purpose: constants and types for the battery-backed sram host port
// Assumes: 20 MHz clock, 50 ns period
// Notes: timing counts derive from the printed nanosecond figures, recovery from the millisecond one
//
// How it works
// R1 - device reads when selected, write high
// R2 - write starts at later falling edge
// R3 - write ends at first rising edge
// R4 - host holds address through whole write
// R5 - address held 15/5 ns after ends
// R6 - data setup 35/40 ns, hold after end
// R7 - host keeps output enable high writing
// R8 - device floats 35 ns after write falls
// R9 - simultaneous select and write: never drives
// R10 - device quiet 5 ns after write rises
// R11 - write pulse at least 65/75 ns
// R12 - select pulse at least 75/90 ns
// R13 - address valid 0 and 75/80 ns before
// R14 - read data within 85/100 ns of address
// R15 - read data within 45/50 ns of enable
// R16 - floats 40 ns after select, 35 output
// R17 - old data held 10 ns on change
// R18 - power fail deselects after protect delay
// R19 - protect delay between 40 and 150 us
// R20 - protected device ignores all inputs
// R21 - access in progress completes on power fail
// R22 - protection enforced anyway when delay expires
// R23 - recovery interval after power fail clears
// R24 - power fail is one input; grade parameter
// R25 - 32768 bytes, 15-bit address, contents persist
package bbs_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    // ****************************************
    // timing figures in ns, recovery delay in ms
    // ****************************************
    localparam int ADDR_TO_VALID_OUT_85_NS = 85;
    localparam int ADDR_TO_VALID_OUT_100_NS = 100;
    localparam int OE_TO_VALID_OUT_85_NS = 45;
    localparam int OE_TO_VALID_OUT_100_NS = 50;
    localparam int CS_RISE_TO_FLOAT_NS = 40;
    localparam int OE_RISE_TO_FLOAT_NS = 35;
    localparam int WR_PULSE_WIDTH_85_NS = 65;
    localparam int WR_PULSE_WIDTH_100_NS = 75;
    localparam int ADDR_TO_WR_END_85_NS = 75;
    localparam int ADDR_TO_WR_END_100_NS = 80;
    localparam int DATA_SETUP_TO_END_85_NS = 35;
    localparam int DATA_SETUP_TO_END_100_NS = 40;
    localparam int ADDR_HOLD_AFTER_CS_NS = 15;
    localparam int DATA_HOLD_AFTER_CS_NS = 15;
    localparam int CS_WRITE_PULSE_85_NS = 75;
    localparam int CS_WRITE_PULSE_100_NS = 90;
    localparam int RECOVERY_DELAY_MS = 120;
    // ****************************************
    // derived cycle counts (least times round up)
    // ****************************************
    function automatic int ns_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_up
    localparam int RD_CYC_85 = ns_up(ADDR_TO_VALID_OUT_85_NS + CS_RISE_TO_FLOAT_NS);
    localparam int RD_CYC_100 = ns_up(ADDR_TO_VALID_OUT_100_NS + CS_RISE_TO_FLOAT_NS);
    localparam int WR_CYC_85 = ns_up(CS_WRITE_PULSE_85_NS);
    localparam int WR_CYC_100 = ns_up(CS_WRITE_PULSE_100_NS);
    localparam int HOLD_CYC = ns_up(ADDR_HOLD_AFTER_CS_NS);
    localparam int RECOVERY_CYC_DEFAULT = RECOVERY_DELAY_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [3:0] CNT_W_ONE = 4'h1;

    typedef enum logic [2:0] {
        BBS_IDLE = 3'b000,
        BBS_SETUP = 3'b001,
        BBS_STROBE = 3'b011,
        BBS_HOLD = 3'b010,
        BBS_FENCE = 3'b110
    } bbs_state_t;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bbs_req_t;

    typedef struct packed {
        logic cs_n;
        logic oe_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
    } bbs_pins_t;
endpackage : bbs_pkg

// ==== src/bbs_timer.sv ====
// Purpose: down counter for host access phases and recovery guard
// Assumes: load wins over count
// Notes: done is high while the count is zero
module bbs_timer #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic load,
    input wire logic [W-1:0] value,
    // status
    output logic done
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= value;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign done = (cnt_q == '0);
endmodule : bbs_timer
